// ===== design/lisi_pkg.sv
package lisi_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] LISI_IDX_RT_STATUS = 8'h18;
    localparam logic [7:0] LISI_IDX_RX_LEVEL = 8'h19;
    localparam logic [7:0] LISI_IDX_EVENTS = 8'h1a;
    localparam logic [7:0] LISI_IDX_IRQ_EN = 8'h1b;
    localparam logic [7:0] LISI_IDX_TX_CTRL = 8'h13;
    localparam logic [7:0] LISI_IDX_RX_MODE = 8'h20;

    // Real-time status bit positions
    localparam int LISI_RT_RX_FAIL = 6;
    localparam int LISI_RT_OVER_EQ = 5;
    localparam int LISI_RT_UNDER_EQ = 4;
    localparam int LISI_RT_OPEN = 2;
    localparam int LISI_RT_SHORT = 1;
    localparam int LISI_RT_LOST = 0;

    // Latched event layout: fall events in [6:4], rise events in [2:0]
    localparam int LISI_EV_FALL_LSB = 4;
    localparam int LISI_EV_RISE_LSB = 0;
    localparam int LISI_EV_GROUP_W = 3;
    localparam logic [7:0] LISI_EV_MASK = 8'h77;

    // Level code sits in the upper nibble
    localparam int LISI_LEVEL_LSB = 4;
    localparam int LISI_LEVEL_W = 4;

    // Receive master-mode fields
    localparam int LISI_MODE_ENABLE = 7;
    localparam int LISI_MODE_INIT_DONE = 6;
    localparam int LISI_MODE_SOFT_RST = 1;
    localparam int LISI_MODE_LINE_TYPE = 0;
    localparam logic [7:0] LISI_MODE_MASK = 8'hc3;

    // Transmit control field
    localparam int LISI_TX_DRV_EN = 0;
    localparam logic [7:0] LISI_TX_CTRL_MASK = 8'h01;

    // Reset values
    localparam logic [7:0] LISI_RST_BYTE = 8'h00;
    localparam logic [31:0] LISI_RST_WORD = 32'h0000_0000;
    localparam logic [23:0] LISI_PAD_HI = 24'h00_0000;

    // Bus answer states
    typedef enum logic [1:0] {
        LISI_ST_IDLE = 2'b01,
        LISI_ST_DONE = 2'b10
    } lisi_bus_state_t;

endpackage

// ===== design/lisi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lisi_link_if;
    logic [7:0] rt_status;  // Sampled real-time flags
    logic [7:0] clr_mask;   // Write-1 clear pulse for events
    logic [7:0] events;     // Latched events
    logic [7:0] irq_enable; // Per-event enables
    logic [7:0] mode;       // Receive master-mode byte
    logic tx_en;            // Transmit driver enable
    logic hiz_a;            // High-impedance control pins
    logic hiz_b;
    logic pos_oe;           // Driver output enables
    logic neg_oe;
    logic irq;              // Interrupt request
    logic fr_enable;        // Framer run
    logic fr_low_power;     // Framer parked
    logic fr_reset;         // Framer held in reset
    logic fr_e1;            // Framer line type

    modport top (output rt_status, clr_mask, irq_enable, mode, tx_en, hiz_a, hiz_b,
                 input events, pos_oe, neg_oe, irq, fr_enable, fr_low_power, fr_reset, fr_e1);
    modport latch (input rt_status, clr_mask, output events);
    modport drive (input events, irq_enable, mode, tx_en, hiz_a, hiz_b,
                   output pos_oe, neg_oe, irq, fr_enable, fr_low_power, fr_reset, fr_e1);
endinterface
`default_nettype wire

// ===== design/lisi_event_latch.sv
`timescale 1ns/1ps
`default_nettype none
module lisi_event_latch
    import lisi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    lisi_link_if.latch lnk
);

    typedef struct packed {
        logic [7:0] prev;   // Flags one cycle earlier
        logic [7:0] events; // Sticky event bits
    } lisi_latch_state_t;

    lisi_latch_state_t r_ff;
    lisi_latch_state_t nxt_r;
    logic [7:0] set_v;

    // Edge detect and sticky update
    always_comb begin
        nxt_r = r_ff;
        set_v = LISI_RST_BYTE;
        // Rising flags land in the low group
        set_v[LISI_EV_RISE_LSB +: LISI_EV_GROUP_W] =
            lnk.rt_status[LISI_RT_LOST +: LISI_EV_GROUP_W] &
            ~r_ff.prev[LISI_RT_LOST +: LISI_EV_GROUP_W];
        // Falling flags land in the high group
        set_v[LISI_EV_FALL_LSB +: LISI_EV_GROUP_W] =
            r_ff.prev[LISI_RT_LOST +: LISI_EV_GROUP_W] &
            ~lnk.rt_status[LISI_RT_LOST +: LISI_EV_GROUP_W];
        // Clear only where a 1 is written; a new edge beats the clear
        nxt_r.events = ((r_ff.events & ~lnk.clr_mask) | set_v) & LISI_EV_MASK;
        nxt_r.prev = lnk.rt_status;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign lnk.events = r_ff.events;

endmodule // lisi_event_latch
`default_nettype wire

// ===== design/lisi_drive.sv
`timescale 1ns/1ps
`default_nettype none
module lisi_drive
    import lisi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    lisi_link_if.drive lnk
);

    typedef struct packed {
        logic pos_oe;
        logic neg_oe;
        logic irq;
        logic fr_enable;
        logic fr_low_power;
        logic fr_reset;
        logic fr_e1;
    } lisi_drive_state_t;

    lisi_drive_state_t r_ff;
    lisi_drive_state_t nxt_r;
    logic drv_on;

    // Pin enables, interrupt merge and framer controls
    always_comb begin
        nxt_r = r_ff;
        // Driver needs the enable and at least one control pin low
        drv_on = lnk.tx_en & (~lnk.hiz_a | ~lnk.hiz_b);
        nxt_r.pos_oe = drv_on;
        nxt_r.neg_oe = drv_on;
        // Any enabled sticky event raises the request
        nxt_r.irq = |(lnk.events & lnk.irq_enable & LISI_EV_MASK);
        // Receiver runs only after init done with the enable set
        nxt_r.fr_enable = lnk.mode[LISI_MODE_ENABLE] & lnk.mode[LISI_MODE_INIT_DONE];
        nxt_r.fr_low_power = ~lnk.mode[LISI_MODE_ENABLE];
        nxt_r.fr_reset = lnk.mode[LISI_MODE_SOFT_RST];
        nxt_r.fr_e1 = lnk.mode[LISI_MODE_LINE_TYPE];
    end

    // State register; framer starts parked like a zero enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '0;
            r_ff.fr_low_power <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign lnk.pos_oe = r_ff.pos_oe;
    assign lnk.neg_oe = r_ff.neg_oe;
    assign lnk.irq = r_ff.irq;
    assign lnk.fr_enable = r_ff.fr_enable;
    assign lnk.fr_low_power = r_ff.fr_low_power;
    assign lnk.fr_reset = r_ff.fr_reset;
    assign lnk.fr_e1 = r_ff.fr_e1;

endmodule // lisi_drive
`default_nettype wire

// ===== design/lisi_top.sv
// Function
// - Driver enable zero floats line outputs
// - Status bit 6 shows receive short
// - Status bit 5 follows over-equalized
// - Status bit 4 follows under-equalized
// - Status bit 2 shows transmit open
// - Status bit 1 shows transmit short
// - Status bit 0 shows signal loss
// - Level register upper nibble shows amplitude
// - Falling flags set event bits 6..4
// - Rising flags set event bits 2..0
// - Events clear only on written one
// - Enabled set event drives interrupt pin
// - Enable bits mask matching events
// - Mode register field layout, receive only
// - Enable zero parks framer low power
// - Init done with enable starts receiver
// - Soft reset bit holds framer reset
// - Line type selects T1 or E1
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lisi_top
    import lisi_pkg::*;
#(
    parameter int ADDR_W = 8 // Byte address width
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_short_fault,
    input wire logic rx_over_equalized,
    input wire logic rx_under_equalized,
    input wire logic tx_open_circuit,
    input wire logic tx_short_circuit,
    input wire logic rx_signal_lost,
    input wire logic [3:0] rx_level_code,
    input wire logic tx_hiz_ctrl_pin_a,
    input wire logic tx_hiz_ctrl_pin_b,
    output logic tx_line_pos_oe,
    output logic tx_line_neg_oe,
    output logic irq_request_pin,
    output logic rx_framer_enable,
    output logic rx_framer_low_power,
    output logic rx_framer_soft_reset,
    output logic rx_line_type_select
);

    // All block state in one record
    typedef struct packed {
        lisi_bus_state_t state;           // Bus answer phase
        logic [31:0] prdata;              // Captured read word
        logic pready;                     // Answer strobe
        logic pslverr;                    // Unmapped access flag
        logic [7:0] line_realtime_status; // Sampled flags
        logic [7:0] line_receive_level;   // Sampled level code
        logic [7:0] line_event_irq_enable;
        logic [7:0] receive_framer_master_mode;
        logic [7:0] tx_driver_control;    // Holds the driver enable
    } lisi_top_state_t;

    lisi_top_state_t r_ff;
    lisi_top_state_t nxt_r;
    logic [7:0] clr_v;
    logic [7:0] wbyte;
    logic wr_go;

    lisi_link_if lnk();

    // Address hit on a register index; low two bits must be zero
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, 2'b00});
        reg_hit = (a == byte_addr);
    endfunction

    // Read multiplexer; unmapped bits and registers read zero
    function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a,
                                           input lisi_top_state_t s,
                                           input logic [7:0] ev);
        rd_byte = LISI_RST_BYTE;
        if (reg_hit(a, LISI_IDX_RT_STATUS)) begin
            rd_byte = s.line_realtime_status;
        end else if (reg_hit(a, LISI_IDX_RX_LEVEL)) begin
            rd_byte = s.line_receive_level;
        end else if (reg_hit(a, LISI_IDX_EVENTS)) begin
            rd_byte = ev & LISI_EV_MASK;
        end else if (reg_hit(a, LISI_IDX_IRQ_EN)) begin
            rd_byte = s.line_event_irq_enable;
        end else if (reg_hit(a, LISI_IDX_TX_CTRL)) begin
            rd_byte = s.tx_driver_control;
        end else if (reg_hit(a, LISI_IDX_RX_MODE)) begin
            rd_byte = s.receive_framer_master_mode;
        end
    endfunction

    // Whether an address names any register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = reg_hit(a, LISI_IDX_RT_STATUS) | reg_hit(a, LISI_IDX_RX_LEVEL) |
                    reg_hit(a, LISI_IDX_EVENTS) | reg_hit(a, LISI_IDX_IRQ_EN) |
                    reg_hit(a, LISI_IDX_TX_CTRL) | reg_hit(a, LISI_IDX_RX_MODE);
    endfunction

    // Next-state logic: flag sampling and the bus slave
    always_comb begin
        nxt_r = r_ff;
        clr_v = LISI_RST_BYTE;
        wbyte = pwdata[7:0];
        wr_go = 1'b0;

        // Flags are re-sampled every cycle, never held
        nxt_r.line_realtime_status = LISI_RST_BYTE;
        nxt_r.line_realtime_status[LISI_RT_RX_FAIL] = rx_short_fault;
        nxt_r.line_realtime_status[LISI_RT_OVER_EQ] = rx_over_equalized;
        nxt_r.line_realtime_status[LISI_RT_UNDER_EQ] = rx_under_equalized;
        nxt_r.line_realtime_status[LISI_RT_OPEN] = tx_open_circuit;
        nxt_r.line_realtime_status[LISI_RT_SHORT] = tx_short_circuit;
        nxt_r.line_realtime_status[LISI_RT_LOST] = rx_signal_lost;
        nxt_r.line_receive_level = LISI_RST_BYTE;
        nxt_r.line_receive_level[LISI_LEVEL_LSB +: LISI_LEVEL_W] = rx_level_code;

        // Answer strobe lasts exactly one cycle
        nxt_r.pready = 1'b0;
        nxt_r.pslverr = 1'b0;

        case (r_ff.state)
            LISI_ST_IDLE: begin
                // First access cycle: capture the answer, raise ready next edge
                if (psel && penable) begin
                    nxt_r.pready = 1'b1;
                    nxt_r.pslverr = ~is_mapped(paddr);
                    if (!pwrite) begin
                        nxt_r.prdata = {LISI_PAD_HI, rd_byte(paddr, r_ff, lnk.events)};
                    end
                    nxt_r.state = LISI_ST_DONE;
                end
            end
            LISI_ST_DONE: begin
                // Ready is seen now; the write commits on this edge only
                nxt_r.state = LISI_ST_IDLE;
                wr_go = psel && penable && pwrite && pstrb[0];
            end
            default: begin
                // Recover from an illegal code
                nxt_r.state = LISI_ST_IDLE;
            end
        endcase

        // Write decode; read-only registers ignore writes
        if (wr_go) begin
            if (reg_hit(paddr, LISI_IDX_EVENTS)) begin
                clr_v = wbyte & LISI_EV_MASK;
            end else if (reg_hit(paddr, LISI_IDX_IRQ_EN)) begin
                nxt_r.line_event_irq_enable = wbyte & LISI_EV_MASK;
            end else if (reg_hit(paddr, LISI_IDX_TX_CTRL)) begin
                nxt_r.tx_driver_control = wbyte & LISI_TX_CTRL_MASK;
            end else if (reg_hit(paddr, LISI_IDX_RX_MODE)) begin
                // Only the four defined mode fields are stored
                nxt_r.receive_framer_master_mode = wbyte & LISI_MODE_MASK;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff.state <= LISI_ST_IDLE;
            r_ff.prdata <= LISI_RST_WORD;
            r_ff.pready <= 1'b0;
            r_ff.pslverr <= 1'b0;
            r_ff.line_realtime_status <= LISI_RST_BYTE;
            r_ff.line_receive_level <= LISI_RST_BYTE;
            r_ff.line_event_irq_enable <= LISI_RST_BYTE;
            r_ff.receive_framer_master_mode <= LISI_RST_BYTE;
            r_ff.tx_driver_control <= LISI_RST_BYTE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Feed the helper modules
    assign lnk.rt_status = r_ff.line_realtime_status;
    assign lnk.clr_mask = clr_v;
    assign lnk.irq_enable = r_ff.line_event_irq_enable;
    // Init-done ordering is left to software; the flops just follow writes
    assign lnk.mode = r_ff.receive_framer_master_mode;
    assign lnk.tx_en = r_ff.tx_driver_control[LISI_TX_DRV_EN];
    assign lnk.hiz_a = tx_hiz_ctrl_pin_a;
    assign lnk.hiz_b = tx_hiz_ctrl_pin_b;

    lisi_event_latch u_latch (
        .pclk(pclk),
        .presetn(presetn),
        .lnk(lnk.latch)
    );

    lisi_drive u_drive (
        .pclk(pclk),
        .presetn(presetn),
        .lnk(lnk.drive)
    );

    // Outputs straight from flops
    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr;
    assign tx_line_pos_oe = lnk.pos_oe;
    assign tx_line_neg_oe = lnk.neg_oe;
    assign irq_request_pin = lnk.irq;
    assign rx_framer_enable = lnk.fr_enable;
    assign rx_framer_low_power = lnk.fr_low_power;
    assign rx_framer_soft_reset = lnk.fr_reset;
    assign rx_line_type_select = lnk.fr_e1;

endmodule // lisi_top
`default_nettype wire

// ===== tb/lisi_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lisi_top_monitor
    import lisi_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_short_fault,
    input wire logic rx_over_equalized,
    input wire logic rx_under_equalized,
    input wire logic tx_open_circuit,
    input wire logic tx_short_circuit,
    input wire logic rx_signal_lost,
    input wire logic [3:0] rx_level_code,
    input wire logic tx_hiz_ctrl_pin_a,
    input wire logic tx_hiz_ctrl_pin_b,
    input wire logic tx_line_pos_oe,
    input wire logic tx_line_neg_oe,
    input wire logic irq_request_pin,
    input wire logic rx_framer_enable,
    input wire logic rx_framer_low_power,
    input wire logic rx_framer_soft_reset,
    input wire logic rx_line_type_select
);
    localparam logic [7:0] A_ST = LISI_IDX_RT_STATUS << 2;
    localparam logic [7:0] A_LV = LISI_IDX_RX_LEVEL << 2;
    localparam logic [7:0] A_EV = LISI_IDX_EVENTS << 2;
    localparam logic [7:0] A_EN = LISI_IDX_IRQ_EN << 2;
    localparam logic [7:0] A_TX = LISI_IDX_TX_CTRL << 2;
    localparam logic [7:0] A_MD = LISI_IDX_RX_MODE << 2;
    logic [7:0] en_ff; // Shadow of the enables, rebuilt from committed writes
    logic [7:0] mode_ff; // Shadow of the mode byte
    logic tx_ff; // Shadow of the driver enable
    logic [2:0] since_ff; // Cycles since an event or enable write, saturating
    wire logic wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    wire logic rd_ok = pready && !pwrite && !pslverr;
    // Shadows follow only writes that commit, so a refused write cannot move them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= 8'h00;
            mode_ff <= 8'h00;
            tx_ff <= 1'b0;
            since_ff <= 3'h7;
        end else begin
            if (wr_ok && paddr == A_EN) en_ff <= pwdata[7:0] & LISI_EV_MASK;
            if (wr_ok && paddr == A_MD) mode_ff <= pwdata[7:0] & LISI_MODE_MASK;
            if (wr_ok && paddr == A_TX) tx_ff <= pwdata[0];
            if (wr_ok && (paddr == A_EV || paddr == A_EN)) since_ff <= 3'h0;
            else if (since_ff != 3'h7) since_ff <= since_ff + 3'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_open_up; $rose(tx_open_circuit) && en_ff[2]; endsequence
    sequence s_lost_gone; $fell(rx_signal_lost) && en_ff[4]; endsequence
    sequence s_irq_soon; ##[1:4] irq_request_pin; endsequence
    a_status_live: assert property (rd_ok && paddr == A_ST |-> prdata[7:0] == {1'b0, $past(rx_short_fault, 2),
        $past(rx_over_equalized, 2), $past(rx_under_equalized, 2), 1'b0, $past(tx_open_circuit, 2),
        $past(tx_short_circuit, 2), $past(rx_signal_lost, 2)}) else $error("status read wrong");
    a_level_live: assert property (rd_ok && paddr == A_LV |-> prdata[7:0] == {$past(rx_level_code, 2), 4'h0})
        else $error("level read wrong");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
    a_rise_irq: assert property (s_open_up |-> s_irq_soon) else $error("rise gave no irq");
    a_fall_irq: assert property (s_lost_gone |-> s_irq_soon) else $error("fall gave no irq");
    a_irq_needs_en: assert property (irq_request_pin |-> $past(en_ff) != 8'h00) else $error("irq unmasked");
    a_irq_holds: assert property ($fell(irq_request_pin) |-> since_ff <= 3'h3) else $error("event lost");
    a_drive_needs_en: assert property (tx_line_pos_oe |-> $past(tx_ff)) else $error("driver without enable");
    a_hiz_float: assert property ($past(tx_hiz_ctrl_pin_a) && $past(tx_hiz_ctrl_pin_b) |-> !tx_line_neg_oe)
        else $error("driver with both pins high");
    a_mode_out: assert property ({rx_framer_enable, rx_framer_low_power, rx_framer_soft_reset, rx_line_type_select}
        == {$past(mode_ff[7] & mode_ff[6]), !$past(mode_ff[7]), $past(mode_ff[1]), $past(mode_ff[0])})
        else $error("framer controls wrong");
endmodule // lisi_top_monitor
bind lisi_top lisi_top_monitor #(.ADDR_W(ADDR_W)) u_lisi_top_monitor (.*);
`default_nettype wire

// ===== tb/lisi_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lisi_top_tb_top
    import lisi_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [5:0] fl = 6'h00; // Live flags {rx_short_fault, oeq, ueq, open, short, lost}
    logic [3:0] lvl = 4'h0;
    logic hza = 1'b1, hzb = 1'b1; // Both high keeps the line driver floating
    wire logic [31:0] prdata;
    wire logic pready, pslverr, pos_oe, neg_oe, irq, fen, flp, frst, fe1;
    int errors = 0, total_checks = 0, cyc = 0;
    logic [31:0] rdv;
    logic er;
    logic [7:0] regs[5] = '{LISI_IDX_RT_STATUS, LISI_IDX_RX_LEVEL, LISI_IDX_EVENTS, LISI_IDX_IRQ_EN, LISI_IDX_RX_MODE};
    int pos[6] = '{0, 1, 2, 4, 5, 6}; // Status position of each flag bit
    // Mode writes: neither, then init done alone, then enable alone, then both; line type always set; soft reset in the first and last
    logic [7:0] mw[5] = '{8'h03, 8'h41, 8'h81, 8'hc1, 8'hff};
    logic [3:0] mo[5] = '{4'h7, 4'h5, 4'h1, 4'h9, 4'hb}; // {enable, low power, reset, E1}
    always #2 pclk = ~pclk;
    lisi_top u_lisi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_short_fault(fl[5]), .rx_over_equalized(fl[4]), .rx_under_equalized(fl[3]), .tx_open_circuit(fl[2]),
        .tx_short_circuit(fl[1]), .rx_signal_lost(fl[0]), .rx_level_code(lvl), .tx_hiz_ctrl_pin_a(hza),
        .tx_hiz_ctrl_pin_b(hzb), .tx_line_pos_oe(pos_oe), .tx_line_neg_oe(neg_oe), .irq_request_pin(irq),
        .rx_framer_enable(fen), .rx_framer_low_power(flp), .rx_framer_soft_reset(frst), .rx_line_type_select(fe1));
    task automatic results();
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        check(nm, rdv, exp);
        check(nm, {31'h0, er}, 32'h0000_0000);
    endtask
    // Flags change after an edge, then settle long enough to reach the events
    task automatic setfl(input logic [5:0] v);
        @(posedge pclk);
        fl <= v;
        repeat (4) @(posedge pclk);
    endtask
    function automatic logic [7:0] ad(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction
    // Hang guard; the run needs a few hundred cycles at most
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check("low_power", {31'h0, flp}, 32'h0000_0001);
        for (int i = 0; i < 5; i++) rchk("reset", ad(regs[i]), 32'h0000_0000);
        // Unmapped read errors, writes to read-only status are dropped
        xfer(1'b0, 8'h70, 32'h0000_0000, 4'h0);
        check("unmapped", {er, rdv[30:0]}, 32'h8000_0000);
        wr(ad(LISI_IDX_RT_STATUS), 32'h0000_00ff);
        rchk("ro_status", ad(LISI_IDX_RT_STATUS), 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            setfl(6'h01 << i);
            rchk("status", ad(LISI_IDX_RT_STATUS), 32'h0000_0001 << pos[i]);
        end
        setfl(6'h00);
        for (int c = 0; c < 16; c += 5) begin
            @(posedge pclk);
            lvl <= c[3:0];
            repeat (3) @(posedge pclk);
            rchk("level", ad(LISI_IDX_RX_LEVEL), {24'h00_0000, c[3:0], 4'h0});
        end
        wr(ad(LISI_IDX_IRQ_EN), 32'hffff_ffff);
        rchk("enable", ad(LISI_IDX_IRQ_EN), 32'h0000_0077);
        wr(ad(LISI_IDX_EVENTS), 32'h0000_0077);
        rchk("ev_clear", ad(LISI_IDX_EVENTS), 32'h0000_0000);
        // Flags lost, short and open: rise, fall, write 1, write 0, strobe off, clear
        for (int i = 0; i < 3; i++) begin
            setfl(6'h01 << i);
            rchk("rise", ad(LISI_IDX_EVENTS), 32'h0000_0001 << i);
            check("irq", {31'h0, irq}, 32'h0000_0001);
            setfl(6'h00);
            rchk("fall", ad(LISI_IDX_EVENTS), 32'h0000_0011 << i);
            wr(ad(LISI_IDX_EVENTS), 32'h0000_0001 << i);
            rchk("w1c", ad(LISI_IDX_EVENTS), 32'h0000_0010 << i);
            wr(ad(LISI_IDX_EVENTS), 32'h0000_0000);
            rchk("w0", ad(LISI_IDX_EVENTS), 32'h0000_0010 << i);
            xfer(1'b1, ad(LISI_IDX_EVENTS), 32'h0000_0010 << i, 4'he);
            rchk("strobe", ad(LISI_IDX_EVENTS), 32'h0000_0010 << i);
            wr(ad(LISI_IDX_EVENTS), 32'h0000_0010 << i);
            rchk("clear", ad(LISI_IDX_EVENTS), 32'h0000_0000);
        end
        // Masking: the open rise event shows on the pin only with its own enable
        setfl(6'h04);
        wr(ad(LISI_IDX_IRQ_EN), 32'h0000_0073);
        repeat (3) @(posedge pclk);
        check("masked", {31'h0, irq}, 32'h0000_0000);
        wr(ad(LISI_IDX_IRQ_EN), 32'h0000_0004);
        repeat (3) @(posedge pclk);
        check("unmasked", {31'h0, irq}, 32'h0000_0001);
        wr(ad(LISI_IDX_EVENTS), 32'h0000_0004);
        setfl(6'h00);
        check("cleared", {31'h0, irq}, 32'h0000_0000);
        wr(ad(LISI_IDX_EVENTS), 32'h0000_0077);
        // Set beats clear: an open rise reaches the latch on the clearing write's commit edge
        setfl(6'h04);
        setfl(6'h00);
        fork
            wr(ad(LISI_IDX_EVENTS), 32'h0000_0004);
            begin
                @(posedge pclk);
                @(posedge pclk);
                fl <= 6'h04;
            end
        join
        rchk("set_wins", ad(LISI_IDX_EVENTS), 32'h0000_0044);
        setfl(6'h00);
        wr(ad(LISI_IDX_EVENTS), 32'h0000_0077);
        // Driver enable against the two control pins
        wr(ad(LISI_IDX_TX_CTRL), 32'h0000_00ff);
        rchk("tx_ctrl", ad(LISI_IDX_TX_CTRL), 32'h0000_0001);
        check("oe_hiz", {30'h0, pos_oe, neg_oe}, 32'h0000_0000);
        hza <= 1'b0;
        repeat (3) @(posedge pclk);
        check("oe_a", {30'h0, pos_oe, neg_oe}, 32'h0000_0003);
        hza <= 1'b1;
        hzb <= 1'b0;
        repeat (3) @(posedge pclk);
        check("oe_b", {30'h0, pos_oe, neg_oe}, 32'h0000_0003);
        wr(ad(LISI_IDX_TX_CTRL), 32'h0000_0000);
        repeat (3) @(posedge pclk);
        check("oe_off", {30'h0, pos_oe, neg_oe}, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            wr(ad(LISI_IDX_RX_MODE), {24'h00_0000, mw[i]});
            repeat (2) @(posedge pclk);
            check("framer", {28'h0, fen, flp, frst, fe1}, {28'h0, mo[i]});
            rchk("mode", ad(LISI_IDX_RX_MODE), {24'h00_0000, mw[i] & 8'hc3});
        end
        results();
    end
endmodule // lisi_top_tb_top
`default_nettype wire
